/* include/hbd_params.svh */
// constants for the half-bridge drive and current chop block
`ifndef HBD_PARAMS_SVH
`define HBD_PARAMS_SVH
// register byte offsets
`define HBD_OFS_SRC      8'h00
`define HBD_OFS_DRIVE    8'h04
`define HBD_OFS_HSMODE   8'h08
`define HBD_OFS_DUTY1    8'h0C
`define HBD_OFS_DUTY2    8'h10
`define HBD_OFS_LEVEL    8'h14
`define HBD_OFS_CHOP     8'h18
`define HBD_OFS_STAT     8'h1C
`define HBD_OFS_PIN      8'h20
// reset values
`define HBD_RST_ZERO     32'h0000_0000
// clock rate and timing
`define HBD_CLK_HZ       40000000
`define HBD_DEAD_NS      100
`define HBD_DEAD_CYC     ((`HBD_DEAD_NS*40+999)/1000)
`define HBD_FILT0_US     2
`define HBD_FILT1_US     5
`define HBD_FILT2_US     10
`define HBD_FILT3_US     20
`define HBD_US_CYC(u)    ((u)*(`HBD_CLK_HZ/1000000))
`define HBD_CHOP0_HZ     20000
`define HBD_CHOP_CYC(h)  (`HBD_CLK_HZ/(h))
`define HBD_HS0_HZ       108
`define HBD_HS1_HZ       217
`define HBD_HS2_HZ       289
`define HBD_HS3_HZ       434
`define HBD_HS_STEPS     1024
`define HBD_HS_PRE(h)    (`HBD_CLK_HZ/((h)*`HBD_HS_STEPS))
`endif

/* include/hbd_pkg.sv */
// types for the half-bridge drive and current chop block
package hbd_pkg;
   typedef enum logic [1:0] {
      HBD_ON   = 2'b00,
      HBD_FREE = 2'b01,
      HBD_HIZ  = 2'b11
   } hbd_phase_e;
   typedef struct packed {
      logic [1:0]  drv;      // high, low fet request after select
      logic [1:0]  out;      // gate outputs
      logic [2:0]  dead;     // dead-time counter
      hbd_phase_e  phase;
      logic [18:0] cnt;      // chop cycle counter
      logic [18:0] off_cnt;  // remaining minimum off time
      logic [9:0]  filt;     // over-limit filter
      logic [9:0]  zfilt;    // zero-current filter
   } hbd_ch_s;
   typedef struct packed {
      logic [17:0] src;
      logic [11:0] drive;
      logic [1:0]  hsmode;
      logic [9:0]  duty1;
      logic [9:0]  duty2;
      logic [9:0]  level;
      logic [17:0] chop;     // filter, rate, minoff, freewheel
      logic [5:0]  trip;
      logic [5:0]  pin_a;
      logic [5:0]  pin_b;
      logic [14:0] hs_pre;
      logic [9:0]  hs_cnt;
      logic        ack;
      logic [31:0] dat;
      hbd_ch_s [5:0] ch;
      logic [11:0] gate;
      logic [5:0]  enable;
      logic [9:0]  lvl_out;
   } hbd_state_s;
endpackage : hbd_pkg

/* core/hbd_core.sv */
// half-bridge gate logic with dead time, high-side mode and current chop
// What this block does
// - source select picks off, register or pwm
// - drive field 00 off, 01 high, 10 low
// - mode writes act at once
// - pwm sources follow the selected pin
// - dead time inserted at every handover
// - bridges one, two have high-side-only bit
// - high-side mode driven by internal generator
// - generator rate code gives four frequencies
// - duty field sets on-time, max 1023
// - high-side mode keeps same chop protection
// - all bridges off after reset
// - sleep low forces both fets off
// - level one bit for one, two bits others
// - freewheel select chooses hi-z or complementary
// - filter code gives 2/5/10/20 us
// - rate code gives 20/10/5/2.5 kHz
// - chop cycle starts when fet enabled
// - trip after filter: off-time, flag, restart
// - zero current in freewheel gives hi-z
// - resume each cycle, pin change restarts count
// - level writes immediate, pins chop like register
// - off time is one full period T from the trip, not max of remainder and minimum, as the trip restarts the count
// - minimum off: none, T/2, T/4, T
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "hbd_params.svh"
module hbd_core (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // pins and analog comparators
   input  wire logic        sleep_n,
   input  wire logic        pwm_input_a,
   input  wire logic        pwm_input_b,
   input  wire logic [5:0]  over_limit,
   input  wire logic [5:0]  zero_current,
   // gate drive: bit 2i high fet, 2i+1 low fet
   output logic      [11:0] gate_on,
   output logic      [5:0]  bridge_enabled,
   output logic      [9:0]  limit_level
);
   ////////////////////////////////////////////////////////////////////
   hbd_pkg::hbd_state_s s_reg;
   hbd_pkg::hbd_state_s s_next;

   // deglitch length in cycles for a filter code
   function automatic logic [9:0] filt_cyc(input logic [1:0] c);
      unique case (c)
         2'b00: filt_cyc = 10'(`HBD_US_CYC(`HBD_FILT0_US));
         2'b01: filt_cyc = 10'(`HBD_US_CYC(`HBD_FILT1_US));
         2'b10: filt_cyc = 10'(`HBD_US_CYC(`HBD_FILT2_US));
         2'b11: filt_cyc = 10'(`HBD_US_CYC(`HBD_FILT3_US));
      endcase
   endfunction : filt_cyc

   // chop period in cycles for a rate code, doubling per step
   function automatic logic [18:0] per_cyc(input logic [1:0] c);
      per_cyc = 19'(`HBD_CHOP_CYC(`HBD_CHOP0_HZ)) << c;
   endfunction : per_cyc

   // generator prescale per rate code
   function automatic logic [14:0] hs_pre(input logic [1:0] c);
      unique case (c)
         2'b00: hs_pre = 15'(`HBD_HS_PRE(`HBD_HS0_HZ));
         2'b01: hs_pre = 15'(`HBD_HS_PRE(`HBD_HS1_HZ));
         2'b10: hs_pre = 15'(`HBD_HS_PRE(`HBD_HS2_HZ));
         2'b11: hs_pre = 15'(`HBD_HS_PRE(`HBD_HS3_HZ));
      endcase
   endfunction : hs_pre

   // requested high and low fet for one bridge
   function automatic logic [1:0] sel_drv(input logic [2:0] src,
      input logic [1:0] drv, input logic a, input logic b);
      unique case (src)
         3'b000: sel_drv = 2'b00;
         3'b001: sel_drv = (drv == 2'b11) ? 2'b00
                                          : {drv[0], drv[1]};
         3'b010: sel_drv = {~a, a};
         3'b011: sel_drv = {1'b0, a};
         3'b100: sel_drv = {a, 1'b0};
         3'b101: sel_drv = {~b, b};
         3'b110: sel_drv = {1'b0, b};
         3'b111: sel_drv = {b, 1'b0};
      endcase
   endfunction : sel_drv

   ////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic [1:0]  req;
      logic [1:0]  want;
      logic [18:0] per;
      logic [18:0] minoff;
      logic [18:0] rem;
      logic [9:0]  fl;
      logic        hit;
      logic        high_fet_on;
      logic        acc;
      logic [2:0]  src;
      logic [1:0]  fsel;
      logic [1:0]  rsel;
      logic [1:0]  msel;
      logic        fw;
      req    = 2'b00;
      want   = 2'b00;
      per    = '0;
      minoff = '0;
      rem    = '0;
      fl     = '0;
      hit    = 1'b0;
      high_fet_on  = 1'b0;
      src    = '0;
      fsel   = '0;
      rsel   = '0;
      msel   = '0;
      fw     = 1'b0;
      s_next = s_reg;
      acc    = wb_cyc_i && wb_stb_i && !s_reg.ack;
      // bus slave, one wait state, ack drops next cycle
      s_next.ack = acc;
      if (acc && wb_we_i && wb_sel_i[0]) begin
         unique case (wb_adr_i)
            `HBD_OFS_SRC:    s_next.src = wb_dat_i[17:0];
            `HBD_OFS_DRIVE:  s_next.drive = wb_dat_i[11:0];
            `HBD_OFS_HSMODE: s_next.hsmode = wb_dat_i[1:0];
            `HBD_OFS_DUTY1:  s_next.duty1 = wb_dat_i[9:0];
            `HBD_OFS_DUTY2:  s_next.duty2 = wb_dat_i[9:0];
            `HBD_OFS_LEVEL:  s_next.level = wb_dat_i[9:0];
            `HBD_OFS_CHOP:   s_next.chop = wb_dat_i[17:0];
            default: ;
         endcase
      end
      if (acc && !wb_we_i) begin
         unique case (wb_adr_i)
            `HBD_OFS_SRC:    s_next.dat = {14'h0, s_reg.src};
            `HBD_OFS_DRIVE:  s_next.dat = {20'h0, s_reg.drive};
            `HBD_OFS_HSMODE: s_next.dat = {30'h0, s_reg.hsmode};
            `HBD_OFS_DUTY1:  s_next.dat = {22'h0, s_reg.duty1};
            `HBD_OFS_DUTY2:  s_next.dat = {22'h0, s_reg.duty2};
            `HBD_OFS_LEVEL:  s_next.dat = {22'h0, s_reg.level};
            `HBD_OFS_CHOP:   s_next.dat = {14'h0, s_reg.chop};
            `HBD_OFS_STAT:   s_next.dat = {26'h0, s_reg.trip};
            `HBD_OFS_PIN:    s_next.dat = {20'h0, s_reg.gate};
            default:         s_next.dat = 32'h0000_0000;
         endcase
      end
      // trip flags clear by writing ones to status
      if (acc && wb_we_i && wb_sel_i[0] && wb_adr_i == `HBD_OFS_STAT)
         s_next.trip = s_reg.trip & ~wb_dat_i[5:0];
      // internal generator shared by bridges one and two
      if (s_reg.hs_pre == 15'h0000) begin
         s_next.hs_pre = hs_pre(s_reg.chop[17:16]) - 15'h0001;
         s_next.hs_cnt = s_reg.hs_cnt + 10'h001;
      end else begin
         s_next.hs_pre = s_reg.hs_pre - 15'h0001;
      end
      // per bridge
      for (int i = 0; i < 6; i++) begin
         src  = s_reg.src[3*i +: 3];
         fsel = s_reg.chop[1:0];
         rsel = s_reg.chop[3:2];
         msel = s_reg.chop[5:4];
         fw   = s_reg.chop[6 + i];
         req  = sel_drv(src, s_reg.drive[2*i +: 2], pwm_input_a, pwm_input_b);
         if (i < 2 && s_reg.hsmode[i]) begin
            high_fet_on = (i == 0) ? (s_reg.hs_cnt < s_reg.duty1)
                             : (s_reg.hs_cnt < s_reg.duty2);
            req = {src[0] & high_fet_on, 1'b0};
         end
         if (!sleep_n)
            req = 2'b00;
         per = per_cyc(rsel);
         fl  = filt_cyc(fsel);
         unique case (msel)
            2'b00: minoff = 19'h0;
            2'b01: minoff = per >> 1;
            2'b10: minoff = per >> 2;
            2'b11: minoff = per;
         endcase
         s_next.ch[i].drv = req;
         hit = 1'b0;
         // command change or fresh enable restarts the chop cycle
         if (req != s_reg.ch[i].drv) begin
            s_next.ch[i].cnt   = '0;
            s_next.ch[i].phase = hbd_pkg::HBD_ON;
            s_next.ch[i].filt  = '0;
            s_next.ch[i].zfilt = '0;
         end else begin
            s_next.ch[i].cnt = s_reg.ch[i].cnt + 19'h1;
            if (s_reg.ch[i].off_cnt != 19'h0)
               s_next.ch[i].off_cnt = s_reg.ch[i].off_cnt - 19'h1;
            if (s_reg.ch[i].cnt >= per - 19'h1) begin
               s_next.ch[i].cnt = '0;
               if (s_reg.ch[i].off_cnt <= 19'h1)
                  s_next.ch[i].phase = hbd_pkg::HBD_ON;
            end
            // over-limit filter, active in on and freewheel phases
            if (over_limit[i] && req != 2'b00 &&
                s_reg.ch[i].phase != hbd_pkg::HBD_HIZ)
               s_next.ch[i].filt = s_reg.ch[i].filt + 10'h001;
            else
               s_next.ch[i].filt = '0;
            if (over_limit[i] && s_reg.ch[i].filt >= fl &&
                s_reg.ch[i].phase == hbd_pkg::HBD_ON && req != 2'b00) begin
               hit = 1'b1;
               s_next.ch[i].filt  = '0;
               s_next.ch[i].cnt   = '0;
               rem = per - s_reg.ch[i].cnt;
               s_next.ch[i].off_cnt = (rem > minoff) ? rem : minoff;
               s_next.ch[i].phase = fw ? hbd_pkg::HBD_FREE
                                       : hbd_pkg::HBD_HIZ;
            end
            // zero crossing during active freewheel
            if (s_reg.ch[i].phase == hbd_pkg::HBD_FREE && zero_current[i])
               s_next.ch[i].zfilt = s_reg.ch[i].zfilt + 10'h001;
            else
               s_next.ch[i].zfilt = '0;
            if (s_reg.ch[i].phase == hbd_pkg::HBD_FREE && zero_current[i] &&
                s_reg.ch[i].zfilt >= fl)
               s_next.ch[i].phase = hbd_pkg::HBD_HIZ;
         end
         if (hit)
            s_next.trip[i] = 1'b1;                        // set wins over clear
         // output after chop phase
         unique case (s_reg.ch[i].phase)
            hbd_pkg::HBD_ON:   want = req;
            hbd_pkg::HBD_FREE: want = (req == 2'b00) ? 2'b00 : ~req;
            hbd_pkg::HBD_HIZ:  want = 2'b00;
            default:           want = 2'b00;
         endcase
         if (!sleep_n || want == 2'b11)
            want = 2'b00;
         // dead time: drop first, then hold both off before turning on
         if (want != s_reg.ch[i].out) begin
            if ((s_reg.ch[i].out & ~want) != 2'b00 || want == 2'b00) begin
               s_next.ch[i].out  = s_reg.ch[i].out & want;
               s_next.ch[i].dead = 3'(`HBD_DEAD_CYC);
            end else if (s_reg.ch[i].dead != 3'h0) begin
               s_next.ch[i].dead = s_reg.ch[i].dead - 3'h1;
            end else begin
               s_next.ch[i].out = want;
            end
         end else if (s_reg.ch[i].dead != 3'h0) begin
            s_next.ch[i].dead = s_reg.ch[i].dead - 3'h1;
         end
         // high fet on the even gate bit, low fet on the odd one
         s_next.gate[2*i +: 2] = {s_next.ch[i].out[0], s_next.ch[i].out[1]};
         s_next.enable[i] = (src != 3'b000) && sleep_n;
      end
      s_next.lvl_out = s_reg.level;
   end

   ////////////////////////////////////////////////////////////////////
   // state register, everything off after reset
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from flip-flops
   assign wb_dat_o       = s_reg.dat;
   assign wb_ack_o       = s_reg.ack;
   assign gate_on        = s_reg.gate;
   assign bridge_enabled = s_reg.enable;
   assign limit_level    = s_reg.lvl_out;
endmodule : hbd_core

/* tb/hbd_load_model.sv */
// load model: current comparators driven by the gate outputs
`timescale 1ns/100ps
module hbd_load_model (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // scenario controls
   input  wire logic        trip_en,
   input  wire logic        zero_en,
   // gate drive at the bridges
   input  wire logic [11:0] gate_on,
   // comparator outputs
   output logic      [5:0]  over_limit,
   output logic      [5:0]  zero_current
);
   logic [9:0]  on_cnt [6];
   logic [11:0] gate_p;
   // time since each bridge last changed its gate pair
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      gate_p <= gate_on;
      for (int i = 0; i < 6; i++) begin
         if (sys_rst || gate_on[2*i +: 2] != gate_p[2*i +: 2])
            on_cnt[i] <= 10'h000;
         else if (on_cnt[i] != 10'h3FF)
            on_cnt[i] <= on_cnt[i] + 10'h001;
      end
   end
   // current rises on the high fet and decays to zero on the low fet
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         over_limit[i] = trip_en & gate_on[2*i] & (on_cnt[i] > 10'd300);
         zero_current[i] = zero_en & gate_on[2*i+1] & (on_cnt[i] > 10'd100);
      end
   end
endmodule : hbd_load_model

/* tb/hbd_core_props.sv */
// port checker for the half-bridge drive block
`timescale 1ns/100ps
`include "hbd_params.svh"
module hbd_core_chk (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   // wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // pins
   input wire logic        sleep_n,
   input wire logic        pwm_input_a,
   input wire logic        pwm_input_b,
   input wire logic [5:0]  over_limit,
   input wire logic [5:0]  zero_current,
   // outputs
   input wire logic [11:0] gate_on,
   input wire logic [5:0]  bridge_enabled,
   input wire logic [9:0]  limit_level
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   logic [5:0]  hi_v, lo_v, hi_rec, lo_rec;
   logic [23:0] hi_h, lo_h;
   logic [9:0]  lvl_want;
   logic        take, take_lvl;
   // split the gates, recent history, bus takes
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         hi_v[i] = gate_on[2*i];
         lo_v[i] = gate_on[2*i+1];
      end
      hi_rec = hi_h[5:0] | hi_h[11:6] | hi_h[17:12] | hi_h[23:18];
      lo_rec = lo_h[5:0] | lo_h[11:6] | lo_h[17:12] | lo_h[23:18];
      take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      take_lvl = take & wb_we_i & wb_sel_i[0];
      take_lvl = take_lvl & (wb_adr_i == `HBD_OFS_LEVEL);
   end
   // last four cycles of gates and the level last written
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         hi_h <= 24'h000000;
         lo_h <= 24'h000000;
         lvl_want <= 10'h000;
      end else begin
         hi_h <= {hi_h[17:0], hi_v};
         lo_h <= {lo_h[17:0], lo_v};
         if (take_lvl)
            lvl_want <= wb_dat_i[9:0];
      end
   end
   ////////////////////////////////////////
   chk_no_shoot: assert property ((hi_v & lo_v) == 6'h00)
      else $error("both fets of a bridge on");
   chk_dead_gap: assert property (((lo_v & ~lo_h[5:0] & hi_rec) |
      (hi_v & ~hi_h[5:0] & lo_rec)) == 6'h00)
      else $error("handover without dead time");
   chk_sleep_off: assert property (!sleep_n [*2] |-> gate_on == 12'h000)
      else $error("gates on while asleep");
   chk_enable_awake: assert property (bridge_enabled != 6'h00 |-> $past(sleep_n))
      else $error("bridge enabled while asleep");
   chk_idle_off: assert property ((bridge_enabled == 6'h00) [*3] |-> gate_on == 12'h000)
      else $error("gates on with no bridge enabled");
   chk_ack_next: assert property (take |=> wb_ack_o)
      else $error("ack not one cycle after take");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i > 8'h20
      |=> wb_dat_o == 32'h00000000)
      else $error("unmapped read not zero");
   chk_level_copy: assert property (take_lvl |-> ##[1:3] limit_level == lvl_want)
      else $error("level output not updated");
   cover property (take_lvl);
   cover property ((lo_v & ~lo_h[5:0]) != 6'h00);
   cover property (!sleep_n ##1 gate_on == 12'h000);
endmodule : hbd_core_chk
////////////////////////////////////////
bind hbd_core hbd_core_chk i_hbd_core_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_n(sleep_n),
   .pwm_input_a(pwm_input_a), .pwm_input_b(pwm_input_b),
   .over_limit(over_limit), .zero_current(zero_current), .gate_on(gate_on),
   .bridge_enabled(bridge_enabled), .limit_level(limit_level));

/* tb/hbd_core_tb.sv */
// self-checking bench for the half-bridge drive block
`timescale 1ns/100ps
`include "hbd_params.svh"
module hbd_core_tb;
   localparam int SETTLE = 4 + `HBD_DEAD_CYC;
   logic sys_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sleep_n;
   logic pwm_input_a, pwm_input_b, trip_en, zero_en;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [5:0] over_limit, zero_current, bridge_enabled;
   logic [11:0] gate_on, w;
   logic [9:0] limit_level;
   logic [1:0] codes [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   hbd_core i_hbd_core (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_n(sleep_n),
      .pwm_input_a(pwm_input_a), .pwm_input_b(pwm_input_b),
      .over_limit(over_limit), .zero_current(zero_current),
      .gate_on(gate_on), .bridge_enabled(bridge_enabled),
      .limit_level(limit_level));
   hbd_load_model i_hbd_load_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .trip_en(trip_en), .zero_en(zero_en), .gate_on(gate_on),
      .over_limit(over_limit), .zero_current(zero_current));
   ////////////////////////////////////////
   // expected {low,high} pair for a drive code or a pin source
   function automatic logic [11:0] exp_reg(input logic [11:0] d);
      for (int i = 0; i < 6; i++)
         exp_reg[2*i +: 2] = {d[2*i+1] & ~d[2*i], d[2*i] & ~d[2*i+1]};
   endfunction : exp_reg
   function automatic logic [1:0] exp_pin(input logic [2:0] s,
      input logic a, input logic b);
      logic p;
      p = (s > 3'd4) ? b : a;
      if (s == 3'd2 || s == 3'd5)
         return {p, ~p};
      return (s == 3'd3 || s == 3'd6) ? {p, 1'b0} : {1'b0, p};
   endfunction : exp_pin
   task automatic chk(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : chk
   // one classic wishbone cycle, entered just after a rising edge
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge sys_clk);
      chk(n < 20, "no ack");
   endtask : wb
   task automatic wait_gate(input logic [1:0] want, input int lim);
      for (int n = 0; n < lim && gate_on[1:0] !== want; n++)
         @(posedge sys_clk);
      chk(gate_on[1:0] === want, "bridge one gate");
   endtask : wait_gate
   task automatic test_done;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   ////////////////////////////////////////
   // clock and hang guard
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         test_done();
      end
   end
   // main sequence
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, pwm_input_a, pwm_input_b} = 5'h00;
      {trip_en, zero_en, wb_adr_i, wb_dat_i} = 42'h0;
      wb_sel_i = 4'hF;
      sleep_n = 1'b1;
      sys_rst = 1'b1;
      void'($urandom(32'h6dbfff71));
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      chk(gate_on === 12'h000 && bridge_enabled === 6'h00, "reset");
      wb(1'b1, `HBD_OFS_SRC, 32'h9249);
      chk(bridge_enabled === 6'h3F, "enables");
      for (int i = 0; i < 8; i++) begin
         w = (i < 4) ? {6{codes[i]}} : 12'($urandom);
         wb(1'b1, `HBD_OFS_DRIVE, {20'h0, w});
         repeat (SETTLE) @(posedge sys_clk);
         chk(gate_on === exp_reg(w), "register drive");
      end
      sleep_n <= 1'b0;
      repeat (SETTLE) @(posedge sys_clk);
      chk(gate_on === 12'h000 && bridge_enabled === 6'h00, "sleep");
      sleep_n <= 1'b1;
      for (int s = 2; s < 8; s++) begin
         wb(1'b1, `HBD_OFS_SRC, s);
         w[0] = 1'($urandom);
         for (int k = 0; k < 4; k++) begin
            pwm_input_a <= k[0] ^ w[0];
            pwm_input_b <= k[1] ^ w[0];
            repeat (SETTLE) @(posedge sys_clk);
            chk(gate_on === {10'h0, exp_pin(s, pwm_input_a, pwm_input_b)}, "pin");
         end
      end
      for (int i = 0; i < 3; i++) begin
         w[9:0] = 10'($urandom);
         wb(1'b1, `HBD_OFS_LEVEL, {22'h0, w[9:0]});
         wb(1'b0, `HBD_OFS_LEVEL, 32'h0);
         chk(rd === {22'h0, w[9:0]} && limit_level === w[9:0], "level");
      end
      wb(1'b1, 8'h40, $urandom);
      wb(1'b0, 8'h40, 32'h0);
      chk(rd === 32'h0, "unmapped");
      wb(1'b1, `HBD_OFS_HSMODE, 32'h1);
      wb(1'b1, `HBD_OFS_CHOP, 32'h30000);
      wb(1'b1, `HBD_OFS_DUTY1, 32'h3FE);
      wb(1'b1, `HBD_OFS_SRC, 32'h1);
      wait_gate(2'b01, 300);
      wb(1'b1, `HBD_OFS_SRC, 32'h2);
      wait_gate(2'b00, SETTLE);
      wb(1'b1, `HBD_OFS_HSMODE, 32'h0);
      wb(1'b1, `HBD_OFS_SRC, 32'h0);
      wb(1'b1, `HBD_OFS_CHOP, 32'h40);
      trip_en <= 1'b1;
      wb(1'b1, `HBD_OFS_DRIVE, 32'h1);
      wb(1'b1, `HBD_OFS_SRC, 32'h1);
      wait_gate(2'b01, SETTLE);
      wait_gate(2'b10, 1000);
      wb(1'b0, `HBD_OFS_STAT, 32'h0);
      chk(rd[0] === 1'b1, "trip flag");
      wait_gate(2'b01, 2500);
      zero_en <= 1'b1;
      wait_gate(2'b10, 1000);
      wait_gate(2'b00, 1000);
      wb(1'b1, `HBD_OFS_CHOP, 32'h0);
      wait_gate(2'b01, 2500);
      wait_gate(2'b00, 1000);
      repeat (100) @(posedge sys_clk);
      chk(gate_on[1:0] === 2'b00, "passive freewheel");
      test_done();
   end
endmodule : hbd_core_tb
